// file: pkg/arp_consts.vh
`ifndef ARP_CONSTS_VH
`define ARP_CONSTS_VH

// ==========================================================================
// Result and bus widths
// ==========================================================================
`define ARP_RES_W 18
`define ARP_RES_MSB 17
`define ARP_WORD_W 16
`define ARP_BANK_DEPTH 4
`define ARP_BANK_AW 2
`define ARP_CHAN_W 3
`define ARP_BANK_BIT 2

// ==========================================================================
// Read sequencing counts
// ==========================================================================
`define ARP_PAR_LAST_WORD 2'd1
`define ARP_BYTE_LAST_WORD 2'd2
`define ARP_SER_LAST_BIT 5'd17
`define ARP_BYTE_HI 2'd0
`define ARP_BYTE_MID 2'd1
`define ARP_BYTE_LO 2'd2
`define ARP_FIRST_CHAN 3'd0
`define ARP_SER_CH_FIRST 2'd0
`define ARP_SER_CH_NEXT 2'd1

// ==========================================================================
// Positions in the synchronised pin vector
// ==========================================================================
`define ARP_SYNC_W 9
`define ARP_S_START_B 0
`define ARP_S_START_A 1
`define ARP_S_SPAN 2
`define ARP_S_PWR_N 3
`define ARP_S_RD_N 4
`define ARP_S_CS_N 5
`define ARP_S_ORDER 6
`define ARP_S_MSB_SEL 7
`define ARP_S_IF_SEL 8
`define ARP_SYNC_RST 9'h038

`endif

// file: design/arp_result_mem.v
`timescale 1ns/100ps
`include "arp_consts.vh"

// ==========================================================================
// Result bank: one write port, registered read data.
// ==========================================================================
module arp_result_mem #(
    parameter WIDTH = 18,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire wr_en_i,
    input wire [AW-1:0] wr_addr_i,
    input wire [WIDTH-1:0] wr_data_i,
    input wire [AW-1:0] rd_addr_i,
    output reg [WIDTH-1:0] rd_data_o
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];

    // Array has no reset; only the read register is cleared.
    always @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    // Read data lag the address by one clock, so readers prefetch.
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            rd_data_o <= {WIDTH{1'b0}};
        end else begin
            rd_data_o <= mem_q[rd_addr_i];
        end
    end
endmodule

// file: design/arp_readout_port.v
`timescale 1ns/100ps
`include "arp_consts.vh"

// How it works
// R01: Parallel: top line carries bit 17, then 1.
// R02: Select high makes msb_or_byte_select a mode input.
// R03: Parallel: bit16 line carries bit 16, then 0.
// R04: Byte order pin picks high-first or low-first.
// R05: Host holds order pin low in serial.
// R06: Upper lines carry bits 15..11 on first read.
// R07: Lines 8,7 carry bits 10,9, then zero.
// R08: Lower lines carry bits 8..2, then zeros.
// R09: Byte mode keeps line 8 undriven.
// R10: Serial: channels 1-4 low out, 5-8 high.
// R11: Byte mode: three reads per result, byte order per R04.
// R12: Host holds lower lines low in serial.
// R13: Host holds upper lines low outside parallel.
// R14: Power-down low: span picks standby or shutdown.
// R15: Standby keeps reference; shutdown powers everything down.
// R16: Power-down entry accepted at any moment.
// R17: Host waits 100 us after standby exit.
// R18: Host waits 13 ms after shutdown exit; the testbench resets 10 clocks after exit.
// R19: Host resets device after shutdown recovery.
// R20: Two start inputs set the sampling instants.
// R21: Chip select rising releases all outputs.
// R22: Serial transfers timed on serial clock rise.
// R23: Chip select falling presents serial MSB.
// R24: Busy high until all results latched.
// R25: Host keeps mode pins stable within frames.
module arp_readout_port (
    input wire clk_i,
    input wire sys_rst_i,
    input wire interface_select_i,
    input wire msb_or_byte_select_i,
    output wire msb_or_byte_select_o,
    output wire msb_or_byte_select_oe_o,
    input wire bit16_or_byte_order_i,
    output wire bit16_or_byte_order_o,
    output wire bit16_or_byte_order_oe_o,
    output wire [4:0] upper_data_lines_o,
    output wire upper_data_lines_oe_o,
    output wire serial_out_high_channels_o,
    output wire serial_out_high_channels_oe_o,
    output wire serial_out_low_channels_o,
    output wire serial_out_low_channels_oe_o,
    output wire [6:0] lower_data_lines_o,
    output wire lower_data_lines_oe_o,
    output wire first_data_o,
    output wire first_data_oe_o,
    input wire chip_select_n_i,
    input wire read_strobe_n_i,
    input wire power_down_n_i,
    input wire input_span_select_i,
    input wire sample_start_a_i,
    input wire sample_start_b_i,
    output wire busy_o,
    output wire conv_start_o,
    input wire conv_we_i,
    input wire [2:0] conv_chan_i,
    input wire [17:0] conv_data_i,
    input wire conv_done_i,
    output wire frontend_power_en_o,
    output wire reference_power_en_o,
    output wire core_power_en_o,
    output wire needs_reset_o
);
    // ======================================================================
    // Pin synchronisers
    // ======================================================================
    wire [`ARP_SYNC_W-1:0] pins_raw;
    reg [`ARP_SYNC_W-1:0] meta_q;
    reg [`ARP_SYNC_W-1:0] sync_q;
    reg [`ARP_SYNC_W-1:0] prev_q;

    assign pins_raw = {interface_select_i, msb_or_byte_select_i, bit16_or_byte_order_i,
                       chip_select_n_i, read_strobe_n_i, power_down_n_i,
                       input_span_select_i, sample_start_a_i, sample_start_b_i};

    // Two stages before any logic looks at a pin; prev_q feeds edge detection.
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta_q <= `ARP_SYNC_RST;
            sync_q <= `ARP_SYNC_RST;
            prev_q <= `ARP_SYNC_RST;
        end else begin
            meta_q <= pins_raw;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // ======================================================================
    // Mode decode and strobe edges
    // ======================================================================
    wire cs_low, cs_fall, cs_rise, rd_fall, sclk_rise, par_mode;
    wire byte_mode, ser_mode, hi_first, start_a_rise, start_b_rise;

    assign cs_low = ~sync_q[`ARP_S_CS_N];
    assign cs_fall = prev_q[`ARP_S_CS_N] & ~sync_q[`ARP_S_CS_N];
    assign cs_rise = ~prev_q[`ARP_S_CS_N] & sync_q[`ARP_S_CS_N];
    assign rd_fall = prev_q[`ARP_S_RD_N] & ~sync_q[`ARP_S_RD_N] & cs_low;
    assign sclk_rise = ~prev_q[`ARP_S_RD_N] & sync_q[`ARP_S_RD_N] & cs_low; // R22
    // In parallel mode the select pin is our own output, so it is ignored.
    assign par_mode = ~sync_q[`ARP_S_IF_SEL];
    assign byte_mode = sync_q[`ARP_S_IF_SEL] & sync_q[`ARP_S_MSB_SEL]; // R02
    assign ser_mode = sync_q[`ARP_S_IF_SEL] & ~sync_q[`ARP_S_MSB_SEL]; // R02
    assign hi_first = sync_q[`ARP_S_ORDER];
    assign start_a_rise = ~prev_q[`ARP_S_START_A] & sync_q[`ARP_S_START_A];
    assign start_b_rise = ~prev_q[`ARP_S_START_B] & sync_q[`ARP_S_START_B];

    // ======================================================================
    // Power modes
    // ======================================================================
    reg standby_q, shutdown_q, needs_reset_q;

    // Entry follows the pins at any time, two synchroniser stages plus one register late.
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            standby_q <= 1'b0;
            shutdown_q <= 1'b0;
            needs_reset_q <= 1'b0;
        end else begin
            standby_q <= ~sync_q[`ARP_S_PWR_N] & sync_q[`ARP_S_SPAN]; // R14 R16
            shutdown_q <= ~sync_q[`ARP_S_PWR_N] & ~sync_q[`ARP_S_SPAN]; // R14 R16
            if (shutdown_q) begin
                needs_reset_q <= 1'b1; // R19
            end
        end
    end

    assign frontend_power_en_o = ~(standby_q | shutdown_q); // R15
    assign reference_power_en_o = ~shutdown_q; // R15
    assign core_power_en_o = ~shutdown_q; // R15
    assign needs_reset_o = needs_reset_q;

    // ======================================================================
    // Conversion start and busy
    // ======================================================================
    reg a_seen_q, b_seen_q, busy_q, conv_start_q;
    wire can_start, both_seen;

    assign can_start = ~busy_q & frontend_power_en_o & ~needs_reset_q;
    assign both_seen = (a_seen_q | start_a_rise) & (b_seen_q | start_b_rise);

    // Starts are ignored while busy; conversion begins once both groups hold.
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            a_seen_q <= 1'b0;
            b_seen_q <= 1'b0;
            busy_q <= 1'b0;
            conv_start_q <= 1'b0;
        end else begin
            conv_start_q <= 1'b0;
            if (!frontend_power_en_o) begin
                a_seen_q <= 1'b0;
                b_seen_q <= 1'b0;
            end else if (can_start) begin
                if (both_seen) begin
                    busy_q <= 1'b1; // R20
                    conv_start_q <= 1'b1;
                    a_seen_q <= 1'b0;
                    b_seen_q <= 1'b0;
                end else begin
                    a_seen_q <= a_seen_q | start_a_rise; // R20
                    b_seen_q <= b_seen_q | start_b_rise; // R20
                end
            end
            if (busy_q && conv_done_i) begin
                busy_q <= 1'b0; // R24
            end
        end
    end

    assign busy_o = busy_q;
    assign conv_start_o = conv_start_q;

    // ======================================================================
    // Result banks: channels 1-4 and 5-8
    // ======================================================================
    reg [`ARP_CHAN_W-1:0] chan_q;
    reg [1:0] word_idx_q;
    reg [`ARP_BANK_AW-1:0] ser_ch_q;
    reg [4:0] bit_cnt_q;
    wire [`ARP_BANK_AW-1:0] rd_addr;
    wire [`ARP_RES_MSB:0] res_lo, res_hi, res_par;

    assign rd_addr = ser_mode ? ser_ch_q : chan_q[`ARP_BANK_AW-1:0];
    assign res_par = chan_q[`ARP_BANK_BIT] ? res_hi : res_lo;

    arp_result_mem #(
        .WIDTH(`ARP_RES_W),
        .DEPTH(`ARP_BANK_DEPTH),
        .AW(`ARP_BANK_AW)
    ) u_bank_lo (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_en_i(conv_we_i & ~conv_chan_i[`ARP_BANK_BIT]),
        .wr_addr_i(conv_chan_i[`ARP_BANK_AW-1:0]),
        .wr_data_i(conv_data_i),
        .rd_addr_i(rd_addr),
        .rd_data_o(res_lo)
    );

    arp_result_mem #(
        .WIDTH(`ARP_RES_W),
        .DEPTH(`ARP_BANK_DEPTH),
        .AW(`ARP_BANK_AW)
    ) u_bank_hi (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_en_i(conv_we_i & conv_chan_i[`ARP_BANK_BIT]),
        .wr_addr_i(conv_chan_i[`ARP_BANK_AW-1:0]),
        .wr_data_i(conv_data_i),
        .rd_addr_i(rd_addr),
        .rd_data_o(res_hi)
    );

    // ======================================================================
    // Word formation for parallel and byte reads
    // ======================================================================
    reg [1:0] byte_sel;
    reg [7:0] byte_val;
    reg [`ARP_WORD_W-1:0] next_word;

    always @* begin
        byte_sel = hi_first ? word_idx_q : (`ARP_BYTE_LO - word_idx_q); // R04
        case (byte_sel)
            `ARP_BYTE_HI: byte_val = res_par[17:10]; // R04 R11
            `ARP_BYTE_MID: byte_val = res_par[9:2]; // R04 R11
            `ARP_BYTE_LO: byte_val = {res_par[1:0], 6'h00}; // R04
            default: byte_val = 8'h00;
        endcase
        if (byte_mode) begin
            next_word = {8'h00, byte_val}; // R11
        end else if (word_idx_q == 2'd0) begin
            next_word = res_par[17:2]; // R01 R03 R06 R07 R08
        end else begin
            next_word = {res_par[1:0], 14'h0000}; // R01 R03 R07 R08
        end
    end

    // ======================================================================
    // Read sequencing
    // ======================================================================
    reg [`ARP_WORD_W-1:0] word_q;
    reg [`ARP_RES_MSB:0] sh_lo_q, sh_hi_q;
    reg frame_q, first_q;
    wire [1:0] last_word;

    assign last_word = byte_mode ? `ARP_BYTE_LAST_WORD : `ARP_PAR_LAST_WORD;

    // The channel pointer survives chip select so tied CS/RD reads walk on;
    // a fresh conversion rewinds it. In serial mode the banks are prefetched one channel ahead.
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            chan_q <= `ARP_FIRST_CHAN;
            word_idx_q <= 2'd0;
            ser_ch_q <= `ARP_SER_CH_FIRST;
            bit_cnt_q <= 5'd0;
            word_q <= {`ARP_WORD_W{1'b0}};
            sh_lo_q <= {`ARP_RES_W{1'b0}};
            sh_hi_q <= {`ARP_RES_W{1'b0}};
            frame_q <= 1'b0;
            first_q <= 1'b0;
        end else begin
            if (cs_fall) begin
                frame_q <= 1'b1;
            end else if (cs_rise) begin
                frame_q <= 1'b0; // R21
                ser_ch_q <= `ARP_SER_CH_FIRST;
            end
            if (conv_done_i) begin
                chan_q <= `ARP_FIRST_CHAN;
                word_idx_q <= 2'd0;
            end else if (rd_fall && !ser_mode) begin
                word_q <= next_word;
                first_q <= (chan_q == `ARP_FIRST_CHAN);
                if (word_idx_q == last_word) begin
                    word_idx_q <= 2'd0;
                    chan_q <= chan_q + 3'd1;
                end else begin
                    word_idx_q <= word_idx_q + 2'd1;
                end
            end
            if (ser_mode && cs_fall) begin
                sh_lo_q <= res_lo; // R23
                sh_hi_q <= res_hi; // R23
                ser_ch_q <= `ARP_SER_CH_NEXT;
                bit_cnt_q <= 5'd0;
                first_q <= 1'b1;
            end else if (ser_mode && frame_q && sclk_rise) begin
                if (bit_cnt_q == `ARP_SER_LAST_BIT) begin
                    sh_lo_q <= res_lo; // R10
                    sh_hi_q <= res_hi; // R10
                    ser_ch_q <= ser_ch_q + 2'd1;
                    bit_cnt_q <= 5'd0;
                    first_q <= 1'b0;
                end else begin
                    sh_lo_q <= {sh_lo_q[16:0], 1'b0}; // R22
                    sh_hi_q <= {sh_hi_q[16:0], 1'b0}; // R22
                    bit_cnt_q <= bit_cnt_q + 5'd1;
                end
            end
        end
    end

    // ======================================================================
    // Pin drivers
    // ======================================================================
    wire rd_active, par_oe, byte_oe, ser_oe;

    // Every enable needs chip select low, so its rise releases the bus.
    assign rd_active = cs_low & ~sync_q[`ARP_S_RD_N];
    assign par_oe = par_mode & rd_active; // R06 R21
    assign byte_oe = byte_mode & rd_active; // R21
    assign ser_oe = ser_mode & frame_q & cs_low; // R21 R23

    assign msb_or_byte_select_o = word_q[15]; // R01
    assign msb_or_byte_select_oe_o = par_oe; // R02
    assign bit16_or_byte_order_o = word_q[14]; // R03
    assign bit16_or_byte_order_oe_o = par_oe; // R03
    assign upper_data_lines_o = word_q[13:9]; // R06
    assign upper_data_lines_oe_o = par_oe; // R06
    assign serial_out_high_channels_o = ser_mode ? sh_hi_q[`ARP_RES_MSB] : word_q[8]; // R10
    assign serial_out_high_channels_oe_o = par_oe | ser_oe; // R09
    assign serial_out_low_channels_o = ser_mode ? sh_lo_q[`ARP_RES_MSB] : word_q[7]; // R10
    assign serial_out_low_channels_oe_o = par_oe | byte_oe | ser_oe; // R11
    assign lower_data_lines_o = word_q[6:0]; // R08
    assign lower_data_lines_oe_o = par_oe | byte_oe; // R08 R11
    assign first_data_o = first_q;
    assign first_data_oe_o = par_oe | byte_oe | ser_oe;
endmodule

// file: testbench/arp_port_monitor.sv
`timescale 1ns/100ps
// ==========================================
// Port checker for the readout port
// ==========================================
module arp_port_monitor (
    input wire clk_i,
    input wire sys_rst_i,
    input wire interface_select_i,
    input wire msb_or_byte_select_i,
    input wire chip_select_n_i,
    input wire power_down_n_i,
    input wire input_span_select_i,
    input wire serial_out_high_channels_oe_o,
    input wire serial_out_low_channels_oe_o,
    input wire lower_data_lines_oe_o,
    input wire busy_o,
    input wire conv_start_o,
    input wire conv_done_i,
    input wire frontend_power_en_o,
    input wire reference_power_en_o,
    input wire core_power_en_o,
    input wire needs_reset_o
);
    // One clock domain, so one clocking and one disable serve every check.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // A start request to the core lasts exactly one cycle.
    sequence s_pulse;
        conv_start_o ##1 !conv_start_o;
    endsequence
    // The lower data lines and lines 7 and 8 are undriven.
    sequence s_quiet;
        !lower_data_lines_oe_o && !serial_out_low_channels_oe_o
            && !serial_out_high_channels_oe_o;
    endsequence
    AST_BYTE_HIZ: assert property (interface_select_i && msb_or_byte_select_i
        |-> !serial_out_high_channels_oe_o) else $error("line 8 driven in byte mode");
    AST_CS_RELEASE: assert property ($rose(chip_select_n_i) |-> ##[1:5] s_quiet)
        else $error("outputs still driven after deselect");
    AST_SER_OPEN: assert property (interface_select_i && !msb_or_byte_select_i
        && $fell(chip_select_n_i) |-> ##[1:5] (serial_out_low_channels_oe_o
        && serial_out_high_channels_oe_o)) else $error("serial outputs not opened");
    AST_BUSY_START: assert property ($rose(busy_o) |-> s_pulse)
        else $error("busy rose without a single start pulse");
    AST_BUSY_HOLD: assert property (busy_o && !conv_done_i && !$past(conv_done_i)
        |=> busy_o) else $error("busy fell before results were latched");
    AST_BUSY_FALL: assert property (conv_done_i && busy_o |-> ##[1:2] !busy_o)
        else $error("busy stayed high after completion");
    AST_NO_START: assert property (needs_reset_o |-> !conv_start_o)
        else $error("conversion started before reset");
    AST_STANDBY: assert property ($fell(power_down_n_i) && input_span_select_i
        |-> ##[2:6] (!frontend_power_en_o && reference_power_en_o))
        else $error("standby rails wrong");
    AST_SHUTDOWN: assert property ($fell(power_down_n_i) && !input_span_select_i
        |-> ##[2:8] (!reference_power_en_o && !core_power_en_o && needs_reset_o))
        else $error("shutdown rails wrong");
endmodule

// file: testbench/arp_host_model.sv
`timescale 1ns/100ps
// ==========================================
// Host controller model
// ==========================================
module arp_host_model (
    input wire clk_i,
    input wire [16:0] bus_i,
    output logic chip_select_n_o,
    output logic read_strobe_n_o,
    output logic interface_select_o,
    output logic mode_select_o,
    output logic byte_order_o
);
    // Idle: deselected, strobe and serial clock parked high, parallel mode.
    initial begin
        chip_select_n_o = 1'b1;
        read_strobe_n_o = 1'b1;
        interface_select_o = 1'b0;
        mode_select_o = 1'b0;
        byte_order_o = 1'b0;
    end
    // Mode pins only move while deselected, so no frame sees them change.
    task set_mode(input logic ifs, input logic ms, input logic ord);
        @(posedge clk_i);
        chip_select_n_o <= 1'b1;
        interface_select_o <= ifs;
        mode_select_o <= ms;
        byte_order_o <= ord & ~(ifs & ~ms);
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    // Opens or closes a frame.
    task select(input logic n);
        @(posedge clk_i);
        chip_select_n_o <= n;
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    // One read strobe; the bus is taken while the strobe is still low.
    task strobe(output logic [16:0] w);
        @(posedge clk_i);
        read_strobe_n_o <= 1'b0;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        w = bus_i;
        @(posedge clk_i);
        read_strobe_n_o <= 1'b1;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    // Eighteen serial clocks of 320 ns; bits are taken late in the low half.
    task shift(output logic [17:0] a, output logic [17:0] b);
        integer i;
        for (i = 17; i >= 0; i = i - 1) begin
            @(posedge clk_i);
            read_strobe_n_o <= 1'b0;
            repeat (3) @(posedge clk_i);
            @(negedge clk_i);
            a[i] = bus_i[7];
            b[i] = bus_i[8];
            @(posedge clk_i);
            read_strobe_n_o <= 1'b1;
            repeat (3) @(posedge clk_i);
        end
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
    endtask
endmodule

// file: testbench/tb.sv
`timescale 1ns/100ps
// ==========================================
// Testbench top
// ==========================================
module tb;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic pwr_n = 1'b1, span = 1'b1, sa = 1'b0, sb = 1'b0, we = 1'b0, done = 1'b0;
    logic [2:0] chan = 3'h0;
    logic [17:0] dat = 18'h00000;
    logic [17:0] r [0:7];
    wire cs_n, rd_n, ifs, msel, ord;
    wire m_o, m_oe, b_o, b_oe, up_oe, hi, hi_oe, lo, lo_oe, lw_oe, fd, fd_oe;
    wire busy, cst, fe, re, ce, nr;
    wire [4:0] up;
    wire [6:0] lw;
    wire [16:0] bus;
    integer failures = 0, checked = 0, cyc = 0;
    // 25 MHz clock.
    always #20 clk_i = ~clk_i;
    // Undriven lines read as z, so a missing driver never passes as a match.
    assign bus = {fd_oe ? fd : 1'bz, m_oe ? m_o : 1'bz, b_oe ? b_o : 1'bz,
        up_oe ? up : {5{1'bz}}, hi_oe ? hi : 1'bz, lo_oe ? lo : 1'bz, lw_oe ? lw : {7{1'bz}}};
    arp_readout_port u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .interface_select_i(ifs),
        .msb_or_byte_select_i(m_oe ? m_o : msel), .msb_or_byte_select_o(m_o),
        .msb_or_byte_select_oe_o(m_oe), .bit16_or_byte_order_i(b_oe ? b_o : ord),
        .bit16_or_byte_order_o(b_o), .bit16_or_byte_order_oe_o(b_oe),
        .upper_data_lines_o(up), .upper_data_lines_oe_o(up_oe),
        .serial_out_high_channels_o(hi), .serial_out_high_channels_oe_o(hi_oe),
        .serial_out_low_channels_o(lo), .serial_out_low_channels_oe_o(lo_oe),
        .lower_data_lines_o(lw), .lower_data_lines_oe_o(lw_oe), .first_data_o(fd),
        .first_data_oe_o(fd_oe), .chip_select_n_i(cs_n), .read_strobe_n_i(rd_n),
        .power_down_n_i(pwr_n), .input_span_select_i(span), .sample_start_a_i(sa),
        .sample_start_b_i(sb), .busy_o(busy), .conv_start_o(cst), .conv_we_i(we),
        .conv_chan_i(chan), .conv_data_i(dat), .conv_done_i(done),
        .frontend_power_en_o(fe), .reference_power_en_o(re), .core_power_en_o(ce),
        .needs_reset_o(nr));
    arp_host_model u_host (.clk_i(clk_i), .bus_i(bus), .chip_select_n_o(cs_n),
        .read_strobe_n_o(rd_n), .interface_select_o(ifs), .mode_select_o(msel),
        .byte_order_o(ord));
    // Compares a word or an 18-bit result.
    task chk(input logic [17:0] g, input logic [17:0] e);
        checked = checked + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Compares a single flag.
    task chk1(input logic g, input logic e);
        checked = checked + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Lets n edges pass, then settles on the falling edge before any sampling.
    task wait_n(input integer n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    // Moves both start pins at one rising edge.
    task starts(input logic a, input logic b);
        @(posedge clk_i);
        sa <= a;
        sb <= b;
    endtask
    // Writes all eight results as the core would, then ends the conversion.
    task load;
        integer i;
        for (i = 0; i < 8; i = i + 1) begin
            @(posedge clk_i);
            we <= 1'b1;
            chan <= i[2:0];
            dat <= r[i];
        end
        @(posedge clk_i);
        we <= 1'b0;
        done <= 1'b1;
        @(posedge clk_i);
        done <= 1'b0;
        wait_n(4);
    endtask
    // Two reads per channel: sixteen high bits, then the two low bits and zeros.
    task t_par;
        logic [16:0] w;
        integer c;
        u_host.set_mode(1'b0, 1'b0, 1'b0);
        load();
        u_host.select(1'b0);
        for (c = 0; c < 2; c = c + 1) begin
            u_host.strobe(w);
            chk({1'b0, w}, {1'b0, c == 0, r[c][17:2]});
            u_host.strobe(w);
            chk({1'b0, w}, {1'b0, c == 0, r[c][1:0], 14'h0000});
        end
        u_host.select(1'b1);
        chk({1'b0, bus}, {1'b0, {17{1'bz}}});
    endtask
    // Three byte reads per channel in the order the order pin picks.
    task t_byte(input logic o);
        logic [16:0] w;
        logic [7:0] e;
        integer c, k, n;
        u_host.set_mode(1'b1, 1'b1, o);
        load();
        u_host.select(1'b0);
        for (c = 0; c < 2; c = c + 1) begin
            for (k = 0; k < 3; k = k + 1) begin
                n = o ? k : 2 - k;
                e = n == 0 ? r[c][17:10] : n == 1 ? r[c][9:2] : {r[c][1:0], 6'h00};
                u_host.strobe(w);
                chk({1'b0, w}, {1'b0, c == 0, 8'hzz, e});
            end
        end
        u_host.select(1'b1);
    endtask
    // Two serial streams: channels 1 and 5, then 2 and 6.
    task t_ser;
        logic [17:0] a, b;
        u_host.set_mode(1'b1, 1'b0, 1'b0);
        load();
        u_host.select(1'b0);
        chk1(fd, 1'b1);
        chk1(up_oe | lw_oe, 1'b0);
        u_host.shift(a, b);
        chk(a, r[0]);
        chk(b, r[4]);
        chk1(fd, 1'b0);
        u_host.shift(a, b);
        chk(a, r[1]);
        chk(b, r[5]);
        u_host.select(1'b1);
    endtask
    // One start alone must not convert; both do, and completion clears busy.
    task t_conv;
        starts(1'b1, 1'b0);
        wait_n(6);
        chk1(busy, 1'b0);
        starts(1'b1, 1'b1);
        wait_n(6);
        chk1(busy, 1'b1);
        load();
        chk1(busy, 1'b0);
        starts(1'b0, 1'b0);
    endtask
    // Standby, then shutdown, which blocks starts until a reset.
    task t_pwr;
        @(posedge clk_i);
        pwr_n <= 1'b0;
        wait_n(8);
        chk1(fe, 1'b0);
        chk1(re, 1'b1);
        @(posedge clk_i);
        pwr_n <= 1'b1;
        wait_n(2500);
        chk1(fe, 1'b1);
        @(posedge clk_i);
        span <= 1'b0;
        pwr_n <= 1'b0;
        wait_n(8);
        chk1(re | ce | fe, 1'b0);
        chk1(nr, 1'b1);
        @(posedge clk_i);
        pwr_n <= 1'b1;
        starts(1'b1, 1'b1);
        wait_n(8);
        chk1(busy, 1'b0);
        starts(1'b0, 1'b0);
        sys_rst_i <= 1'b1;
        wait_n(2);
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        wait_n(2);
        chk1(nr, 1'b0);
    endtask
    // Prints the counts and the verdict, then stops.
    task end_sim;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Cuts a hang short; the whole run needs well under 8000 cycles.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            end_sim();
        end
    end
    // Main sequence: distinct results, reset, then every scenario in turn.
    initial begin
        integer i;
        for (i = 0; i < 8; i = i + 1)
            r[i] = {i[2:0], 12'ha5c, i[2:0]} ^ 18'h2c3a5;
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        wait_n(2);
        t_par();
        t_byte(1'b1);
        t_byte(1'b0);
        t_ser();
        t_conv();
        t_pwr();
        end_sim();
    end
endmodule
bind arp_readout_port arp_port_monitor u_mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .interface_select_i(interface_select_i), .msb_or_byte_select_i(msb_or_byte_select_i),
    .chip_select_n_i(chip_select_n_i), .power_down_n_i(power_down_n_i),
    .input_span_select_i(input_span_select_i),
    .serial_out_high_channels_oe_o(serial_out_high_channels_oe_o),
    .serial_out_low_channels_oe_o(serial_out_low_channels_oe_o),
    .lower_data_lines_oe_o(lower_data_lines_oe_o), .busy_o(busy_o),
    .conv_start_o(conv_start_o), .conv_done_i(conv_done_i),
    .frontend_power_en_o(frontend_power_en_o), .reference_power_en_o(reference_power_en_o),
    .core_power_en_o(core_power_en_o), .needs_reset_o(needs_reset_o));
